/* File: core/if_frequency_counter.sv */
// Gated IF frequency counter with prefix/timer readout and AXI4-Lite control.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module if_frequency_counter
  import freq_counter_pkg::*;
#(
  parameter int TICKS_10HZ  = GATE_TICKS_10HZ,
  parameter int TICKS_100HZ = GATE_TICKS_100HZ,
  parameter int TICKS_FINE  = GATE_TICKS_FINE
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ref_10mhz,
  input  wire logic        host_bus_4mhz_clock,
  input  wire logic        measured_input,
  input  wire logic        irq_ack_line,
  input  wire logic        prefix_read_n,
  input  wire logic        timer_select_n,
  input  wire logic        timer_read_n,
  output logic [7:0]       internal_data_bus,
  output logic             bus_oe_n,
  output logic             gate_pulse,
  output logic             timer_ch0_output,
  output logic             overflow_irq,
  output logic             count_done_irq,
  output logic             irq
);

  typedef enum logic {ST_IDLE, ST_GATE} gate_state_t;

  function automatic logic [NIBBLE_W-1:0] nibble_inc(input logic [NIBBLE_W-1:0] v,
                                                    input logic en);
    nibble_inc = en ? NIBBLE_W'(v + 1'b1) : v;
  endfunction

  function automatic logic [GATE_W-1:0] gate_load(input logic [2:0] res);
    // Loaded value is one less: terminal fires after the full count
    if (res == RES_10HZ) begin
      gate_load = GATE_W'(TICKS_10HZ - 1);
    end else if (res == RES_100HZ) begin
      gate_load = GATE_W'(TICKS_100HZ - 1);
    end else begin
      gate_load = GATE_W'(TICKS_FINE - 1);
    end
  endfunction

  gate_state_t        state;
  gate_state_t        next_state;
  logic               ref_prev;
  logic               bus_clk_prev;
  logic               meas_prev;
  logic               rd_active_prev;
  logic [NIBBLE_W-1:0] prefix_lo;
  logic [NIBBLE_W-1:0] prefix_hi;
  logic [NIBBLE_W-1:0] next_prefix_lo;
  logic [NIBBLE_W-1:0] next_prefix_hi;
  logic               zero_span;
  logic [2:0]         resolution;
  logic [IRQ_W-1:0]   int_status;
  logic [IRQ_W-1:0]   int_enable;
  logic               timer_byte_hi;
  logic               aw_held;
  logic               w_held;
  logic [7:0]         aw_addr_q;
  logic [7:0]         w_data_q;
  logic               w_lane0_q;
  logic               next_zero_span;
  logic [2:0]         next_resolution;
  logic [IRQ_W-1:0]   next_int_status;
  logic [IRQ_W-1:0]   next_int_enable;
  logic               next_timer_byte_hi;
  logic               next_aw_held;
  logic               next_w_held;
  logic [7:0]         next_aw_addr_q;
  logic [7:0]         next_w_data_q;
  logic               next_w_lane0_q;
  logic               next_awready;
  logic               next_wready;
  logic [1:0]         next_bresp;
  logic               next_bvalid;
  logic               next_arready;
  logic [31:0]        next_rdata;
  logic [1:0]         next_rresp;
  logic               next_rvalid;
  logic [7:0]         next_bus_data;
  logic               next_bus_oe_n;
  logic               next_gate_pulse;
  logic               next_ch0_out;
  logic               next_done_irq;
  logic               start;
  logic               ref_rise;
  logic               bus_clk_rise;
  logic               meas_rise;
  logic               count_edge;
  logic               prefix_wrap;
  logic               ch2_tick;
  logic               gate_end;
  logic               rd_active;
  logic               do_write;
  logic [PREFIX_W-1:0] prefix;
  logic [GROUP_W-1:0] groups;
  logic [GATE_W-1:0]  ch2_count;
  logic [GROUP_W-1:0] ch0_count;
  logic               ch2_terminal;
  logic               ch0_terminal;
  logic               timebase_tick;

  assign prefix       = {prefix_hi, prefix_lo};
  assign ref_rise     = ref_10mhz && !ref_prev;
  assign bus_clk_rise = host_bus_4mhz_clock && !bus_clk_prev;
  // Edge sampling needs the input well below half of aclk
  assign meas_rise    = measured_input && !meas_prev;
  assign count_edge   = meas_rise && (state == ST_GATE) && !gate_pulse;
  assign prefix_wrap  = count_edge && (prefix == '1);
  // Zero span uses the bus clock directly, count mode the prescaled reference
  assign ch2_tick     = zero_span ? bus_clk_rise : timebase_tick;
  assign gate_end     = (state == ST_GATE) && ch2_terminal;
  assign rd_active    = !timer_select_n && !timer_read_n;
  // Channel zero counts down from all ones; inversion gives completed groups
  assign groups       = ~ch0_count;
  assign do_write     = aw_held && w_held && !s_axi_bvalid;
  assign start        = do_write && w_lane0_q && (aw_addr_q == OFS_CTRL)
                        && w_data_q[CTRL_START_BIT];

  tick_divider #(
    .DIV      (PRESCALE_DIV)
  ) u_prescale (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .in_tick  (ref_rise),
    .out_tick (timebase_tick)
  );

  timer_channel #(
    .WIDTH      (GATE_W)
  ) u_gate_timer (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .load       (start),
    .load_value (gate_load(next_resolution)),
    .tick       (ch2_tick),
    .count      (ch2_count),
    .terminal   (ch2_terminal)
  );

  timer_channel #(
    .WIDTH      (GROUP_W)
  ) u_group_timer (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .load       (start),
    .load_value ('1),
    .tick       (prefix_wrap),
    .count      (ch0_count),
    .terminal   (ch0_terminal)
  );

  always_comb begin
    next_state      = state;
    next_prefix_lo  = nibble_inc(prefix_lo, count_edge);
    next_prefix_hi  = nibble_inc(prefix_hi, count_edge && (&prefix_lo));
    next_ch0_out    = timer_ch0_output || ch0_terminal;
    // Set only possible with acknowledge high, so clearing never loses it
    next_done_irq   = (count_done_irq && irq_ack_line) || (gate_end && irq_ack_line);
    if (start) begin
      next_state     = ST_GATE;
      next_prefix_lo = '0;
      next_prefix_hi = '0;
      next_ch0_out   = 1'b0;
    end else if (gate_end) begin
      next_state = ST_IDLE;
    end
    next_gate_pulse = (next_state != ST_GATE);
    next_timer_byte_hi = timer_byte_hi;
    if (start) begin
      next_timer_byte_hi = 1'b0;
    end else if (rd_active_prev && !rd_active) begin
      next_timer_byte_hi = !timer_byte_hi;
    end
    next_bus_oe_n = 1'b1;
    next_bus_data = '0;
    if (!prefix_read_n) begin
      next_bus_oe_n = 1'b0;
      next_bus_data = prefix;
    end else if (rd_active) begin
      next_bus_oe_n = 1'b0;
      next_bus_data = timer_byte_hi ? groups[15:8] : groups[7:0];
    end
  end

  always_comb begin
    next_zero_span  = zero_span;
    next_resolution = resolution;
    next_int_enable = int_enable;
    next_int_status = int_status;
    next_aw_held    = aw_held || (s_axi_awvalid && s_axi_awready);
    next_w_held     = w_held || (s_axi_wvalid && s_axi_wready);
    next_aw_addr_q  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr_q;
    next_w_data_q   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : w_data_q;
    next_w_lane0_q  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : w_lane0_q;
    next_bvalid     = s_axi_bvalid && !s_axi_bready;
    next_bresp      = s_axi_bresp;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (aw_addr_q == OFS_CTRL) begin
        if (w_lane0_q) begin
          next_zero_span  = w_data_q[CTRL_MODE_BIT];
          next_resolution = w_data_q[CTRL_RES_MSB:CTRL_RES_LSB];
        end
      end else if (aw_addr_q == OFS_INT_ENABLE) begin
        if (w_lane0_q) begin
          next_int_enable = w_data_q[IRQ_W-1:0];
        end
      end else if (aw_addr_q == OFS_INT_CLEAR) begin
        if (w_lane0_q) begin
          next_int_status = int_status & ~w_data_q[IRQ_W-1:0];
        end
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    // New events win over a clear in the same cycle
    next_int_status[IRQ_OVF_BIT]  = next_int_status[IRQ_OVF_BIT] || ch0_terminal;
    next_int_status[IRQ_DONE_BIT] = next_int_status[IRQ_DONE_BIT]
                                    || (gate_end && irq_ack_line);
    next_awready = !next_aw_held && !(do_write || s_axi_bvalid);
    next_wready  = !next_w_held && !(do_write || s_axi_bvalid);
    next_arready = !s_axi_rvalid;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      next_rdata   = '0;
      if (s_axi_araddr == OFS_CTRL) begin
        next_rdata[CTRL_MODE_BIT]             = zero_span;
        next_rdata[CTRL_RES_MSB:CTRL_RES_LSB] = resolution;
      end else if (s_axi_araddr == OFS_STATUS) begin
        next_rdata[2:0] = {timer_ch0_output, count_done_irq, state == ST_GATE};
      end else if (s_axi_araddr == OFS_PREFIX) begin
        next_rdata[PREFIX_W-1:0] = prefix;
      end else if (s_axi_araddr == OFS_GROUPS) begin
        next_rdata[GROUP_W-1:0] = groups;
      end else if (s_axi_araddr == OFS_INT_STATUS) begin
        next_rdata[IRQ_W-1:0] = int_status;
      end else if (s_axi_araddr == OFS_INT_ENABLE) begin
        next_rdata[IRQ_W-1:0] = int_enable;
      end else if (s_axi_araddr != OFS_INT_CLEAR) begin
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state             <= ST_IDLE;
      ref_prev          <= 1'b0;
      bus_clk_prev      <= 1'b0;
      meas_prev         <= 1'b0;
      rd_active_prev    <= 1'b0;
      prefix_lo         <= '0;
      prefix_hi         <= '0;
      zero_span         <= 1'b0;
      resolution        <= RES_RESET;
      int_status        <= '0;
      int_enable        <= '0;
      timer_byte_hi     <= 1'b0;
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_addr_q         <= '0;
      w_data_q          <= '0;
      w_lane0_q         <= 1'b0;
      s_axi_awready     <= 1'b0;
      s_axi_wready      <= 1'b0;
      s_axi_bresp       <= RESP_OKAY;
      s_axi_bvalid      <= 1'b0;
      s_axi_arready     <= 1'b0;
      s_axi_rdata       <= '0;
      s_axi_rresp       <= RESP_OKAY;
      s_axi_rvalid      <= 1'b0;
      internal_data_bus <= '0;
      bus_oe_n          <= 1'b1;
      gate_pulse        <= 1'b1;
      timer_ch0_output  <= 1'b0;
      overflow_irq      <= 1'b0;
      count_done_irq    <= 1'b0;
      irq               <= 1'b0;
    end else begin
      state             <= next_state;
      ref_prev          <= ref_10mhz;
      bus_clk_prev      <= host_bus_4mhz_clock;
      meas_prev         <= measured_input;
      rd_active_prev    <= rd_active;
      prefix_lo         <= next_prefix_lo;
      prefix_hi         <= next_prefix_hi;
      zero_span         <= next_zero_span;
      resolution        <= next_resolution;
      int_status        <= next_int_status;
      int_enable        <= next_int_enable;
      timer_byte_hi     <= next_timer_byte_hi;
      aw_held           <= next_aw_held;
      w_held            <= next_w_held;
      aw_addr_q         <= next_aw_addr_q;
      w_data_q          <= next_w_data_q;
      w_lane0_q         <= next_w_lane0_q;
      s_axi_awready     <= next_awready;
      s_axi_wready      <= next_wready;
      s_axi_bresp       <= next_bresp;
      s_axi_bvalid      <= next_bvalid;
      s_axi_arready     <= next_arready;
      s_axi_rdata       <= next_rdata;
      s_axi_rresp       <= next_rresp;
      s_axi_rvalid      <= next_rvalid;
      internal_data_bus <= next_bus_data;
      bus_oe_n          <= next_bus_oe_n;
      gate_pulse        <= next_gate_pulse;
      timer_ch0_output  <= next_ch0_out;
      overflow_irq      <= next_ch0_out;
      count_done_irq    <= next_done_irq;
      irq               <= |(next_int_status & next_int_enable);
    end
  end

  chk_clock_select: assert property (
    @(posedge aclk) disable iff (!aresetn)
    zero_span && bus_clk_rise |-> ch2_tick)
    else $error("bus clock not routed to gate timer");

  chk_gate_opens: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start |=> !gate_pulse ##1 !gate_pulse)
    else $error("gate did not open after start");

  chk_gate_only_count: assert property (
    @(posedge aclk) disable iff (!aresetn)
    gate_pulse && !start |=> prefix == $past(prefix))
    else $error("prefix moved while gate closed");

  chk_prefix_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    count_edge && !start |=> prefix == PREFIX_W'($past(prefix) + 1'b1))
    else $error("prefix did not step on input edge");

  chk_group_tick: assert property (
    @(posedge aclk) disable iff (!aresetn)
    prefix_wrap && !start |=> groups == GROUP_W'($past(groups) + 1'b1))
    else $error("group count did not follow prefix wrap");

  chk_overflow_irq: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ch0_terminal && !start |=> overflow_irq && timer_ch0_output)
    else $error("overflow not flagged");

  chk_done_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    gate_end && irq_ack_line |=> count_done_irq && gate_pulse)
    else $error("count done not raised at gate end");

  chk_done_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !irq_ack_line |=> !count_done_irq)
    else $error("count done survived low acknowledge");

  chk_prefix_drive: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !prefix_read_n |=> !bus_oe_n && internal_data_bus == $past(prefix))
    else $error("prefix not driven on bus");

  chk_timer_drive: assert property (
    @(posedge aclk) disable iff (!aresetn)
    prefix_read_n && rd_active && !timer_byte_hi |=>
      !bus_oe_n && internal_data_bus == $past(groups[7:0]))
    else $error("timer byte not driven on bus");

endmodule

/* File: core/freq_counter_pkg.sv */
// Constants shared by the IF frequency counter and its timer blocks.
package freq_counter_pkg;

  // Input and reference rates
  localparam int CLK_HZ           = 100_000_000;
  localparam int MEAS_NOMINAL_KHZ = 5350;
  localparam int REF_HZ           = 10_000_000;
  localparam int BUS_CLK_HZ       = 4_000_000;
  localparam int ZERO_SPAN_MIN_MS = 30;
  localparam int PRESCALE_DIV     = 5;
  localparam int TIMEBASE_HZ      = REF_HZ / PRESCALE_DIV;

  // Gate times per resolution, and their timebase tick counts
  localparam int GATE_MS_10HZ    = 200;
  localparam int GATE_MS_100HZ   = 20;
  localparam int GATE_MS_FINE    = 2;
  localparam int GATE_TICKS_10HZ  = GATE_MS_10HZ * (TIMEBASE_HZ / 1000);
  localparam int GATE_TICKS_100HZ = GATE_MS_100HZ * (TIMEBASE_HZ / 1000);
  localparam int GATE_TICKS_FINE  = GATE_MS_FINE * (TIMEBASE_HZ / 1000);

  // Counter geometry
  localparam int NIBBLE_W  = 4;
  localparam int PREFIX_W  = 8;
  localparam int GROUP_W   = 16;
  localparam int GATE_W    = 20;

  // Resolution codes
  localparam logic [2:0] RES_10HZ  = 3'h0;
  localparam logic [2:0] RES_100HZ = 3'h1;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_PREFIX     = 8'h08;
  localparam logic [7:0] OFS_GROUPS     = 8'h0C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h14;
  localparam logic [7:0] OFS_INT_CLEAR  = 8'h18;

  // Control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_BIT  = 1;
  localparam int CTRL_RES_LSB   = 2;
  localparam int CTRL_RES_MSB   = 4;

  // Interrupt bits
  localparam int IRQ_W        = 2;
  localparam int IRQ_OVF_BIT  = 0;
  localparam int IRQ_DONE_BIT = 1;

  // Reset values and responses
  localparam logic [2:0]  RES_RESET   = 3'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

/* File: core/tick_divider.sv */
// Divides a stream of single-cycle ticks by a fixed ratio.
`timescale 1ns/1ps
module tick_divider
  import freq_counter_pkg::*;
#(
  parameter int DIV = PRESCALE_DIV
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic in_tick,
  output logic      out_tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_out;

  always_comb begin
    next_cnt = cnt;
    next_out = 1'b0;
    if (in_tick) begin
      if (cnt == CW'(DIV - 1)) begin
        next_cnt = '0;
        next_out = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt      <= '0;
      out_tick <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      out_tick <= next_out;
    end
  end

  chk_div_ratio: assert property (
    @(posedge aclk) disable iff (!aresetn)
    in_tick && cnt == CW'(DIV - 1) |=> out_tick && cnt == '0)
    else $error("divider missed its output tick");

endmodule

/* File: core/timer_channel.sv */
// Loadable down-counting timer channel with a terminal pulse on wrap.
`timescale 1ns/1ps
module timer_channel
  import freq_counter_pkg::*;
#(
  parameter int WIDTH = GROUP_W
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             tick,
  output logic      [WIDTH-1:0] count,
  output logic                  terminal
);

  logic [WIDTH-1:0] next_count;
  logic             next_terminal;

  // Load beats a coincident tick
  always_comb begin
    next_count    = count;
    next_terminal = 1'b0;
    if (load) begin
      next_count = load_value;
    end else if (tick) begin
      next_count    = count - 1'b1;
      next_terminal = (count == '0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count    <= '0;
      terminal <= 1'b0;
    end else begin
      count    <= next_count;
      terminal <= next_terminal;
    end
  end

  chk_timer_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !load && tick && count == '0 |=> terminal && (&count))
    else $error("timer wrap did not raise terminal");

endmodule

/* File: tb/host_cpu_model.sv */
// Host processor model: strobe-driven readout and acknowledge handling.
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic       aclk,
  input  wire logic [7:0] internal_data_bus,
  input  wire logic       bus_oe_n,
  output logic            prefix_read_n,
  output logic            timer_select_n,
  output logic            timer_read_n,
  output logic            irq_ack_line
);
  initial begin
    prefix_read_n  = 1'b1;
    timer_select_n = 1'b1;
    timer_read_n   = 1'b1;
    irq_ack_line   = 1'b1;
  end

  // Holds the strobe until the bus is seen driven, then releases it
  task automatic strobe(input bit t, output logic [7:0] d);
    @(posedge aclk);
    if (t) begin
      timer_select_n <= 1'b0;
      timer_read_n   <= 1'b0;
    end else begin
      prefix_read_n <= 1'b0;
    end
    do @(posedge aclk); while (bus_oe_n !== 1'b0);
    d = internal_data_bus;
    prefix_read_n  <= 1'b1;
    timer_select_n <= 1'b1;
    timer_read_n   <= 1'b1;
    do @(posedge aclk); while (bus_oe_n !== 1'b1);
  endtask

  // Timer bytes come low first, then high
  task automatic readout(output logic [7:0] p, output logic [7:0] lo, output logic [7:0] hi);
    strobe(1'b0, p);
    strobe(1'b1, lo);
    strobe(1'b1, hi);
  endtask

  task automatic ack(input logic v);
    @(posedge aclk);
    irq_ack_line <= v;
  endtask
endmodule

/* File: tb/test_if_frequency_counter.sv */
// Self-checking bench for the IF frequency counter.
`timescale 1ns/1ps
module test_if_frequency_counter;
  import freq_counter_pkg::*;
  localparam int T10 = 40;
  localparam int T100 = 10;
  localparam int TF = 5;
  logic        aclk, aresetn = 0, ref_10mhz = 0, host_bus_4mhz_clock = 0, measured_input = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, internal_data_bus;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irq_ack_line, prefix_read_n, timer_select_n, timer_read_n, bus_oe_n;
  logic        gate_pulse, timer_ch0_output, overflow_irq, count_done_irq, irq;
  int          error_cnt = 0, compares = 0, div = 0;

  if_frequency_counter #(.TICKS_10HZ(T10), .TICKS_100HZ(T100), .TICKS_FINE(TF))
  if_frequency_counter_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ref_10mhz, .host_bus_4mhz_clock, .measured_input,
    .irq_ack_line, .prefix_read_n, .timer_select_n, .timer_read_n, .internal_data_bus,
    .bus_oe_n, .gate_pulse, .timer_ch0_output, .overflow_irq, .count_done_irq, .irq);
  host_cpu_model host_cpu_model_inst (.aclk, .internal_data_bus, .bus_oe_n, .prefix_read_n,
    .timer_select_n, .timer_read_n, .irq_ack_line);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // 10 MHz reference and 4 MHz bus clock as sampled square waves
  always @(posedge aclk) begin
    div <= (div + 1) % 50;
    ref_10mhz <= (div % 10) < 5;
    host_bus_4mhz_clock <= (div % 25) < 12;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic gate_len(output int n);
    n = 0;
    while (gate_pulse !== 1'b0) @(posedge aclk);
    while (gate_pulse === 1'b0) begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge aclk) measured_input <= 1'b1;
      @(posedge aclk);
      @(posedge aclk) measured_input <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    chk("gate idle", 1, gate_pulse);
    chk("bus idle", 1, bus_oe_n);
    rd(OFS_STATUS, d, r);
    chk("status", 0, d);
    rd(8'h1C, d, r);
    chk("unmapped rresp", RESP_SLVERR, r);
    wr(8'h1C, 32'h0000_0001, r);
    chk("unmapped bresp", RESP_SLVERR, r);
  endtask

  // First tick lands anywhere within one tick period after start
  task automatic t_gate();
    logic [1:0] r;
    logic [2:0] res [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h2};
    int n, t, e;
    for (int i = 0; i < 5; i++) begin
      t = (i == 4) ? 25 : 50;
      e = (res[i] == 3'h0) ? T10 : (res[i] == 3'h1) ? T100 : TF;
      wr(OFS_CTRL, {27'h0, res[i], i == 4, 1'b1}, r);
      gate_len(n);
      chk("gate length", 1, n >= (e - 1) * t && n <= e * t + 4);
    end
  endtask

  task automatic t_count();
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] p, lo, hi;
    host_cpu_model_inst.ack(1'b0);
    host_cpu_model_inst.ack(1'b1);
    wr(OFS_INT_CLEAR, 32'h0000_0003, r);
    wr(OFS_CTRL, 32'h0000_0001, r);
    while (gate_pulse !== 1'b0) @(posedge aclk);
    pulses(300);
    while (gate_pulse !== 1'b1) @(posedge aclk);
    pulses(10);
    repeat (3) @(posedge aclk);
    chk("done irq", 1, count_done_irq);
    host_cpu_model_inst.readout(p, lo, hi);
    chk("prefix", 300 % 256, p);
    chk("groups", 300 / 256, {hi, lo});
    chk("total", 300, {hi, lo} * 256 + p);
    rd(OFS_PREFIX, d, r);
    chk("prefix reg", 300 % 256, d);
    rd(OFS_GROUPS, d, r);
    chk("groups reg", 300 / 256, d);
    rd(OFS_INT_STATUS, d, r);
    chk("int status done", 32'h0000_0002, d);
    chk("no overflow", 0, overflow_irq);
    chk("ch0 output", 0, timer_ch0_output);
    host_cpu_model_inst.ack(1'b0);
    repeat (3) @(posedge aclk);
    chk("done cleared", 0, count_done_irq);
    wr(OFS_INT_ENABLE, 32'h0000_0002, r);
    @(posedge aclk);
    chk("irq on", 1, irq);
    wr(OFS_INT_ENABLE, 32'h0000_0000, r);
    @(posedge aclk);
    chk("irq masked", 0, irq);
    wr(OFS_INT_ENABLE, 32'h0000_0002, r);
    wr(OFS_INT_CLEAR, 32'h0000_0002, r);
    @(posedge aclk);
    chk("irq cleared", 0, irq);
  endtask

  task automatic t_noack();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(OFS_CTRL, 32'h0000_0009, r);
    gate_len(n);
    repeat (3) @(posedge aclk);
    chk("done without ack", 0, count_done_irq);
    rd(OFS_INT_STATUS, d, r);
    chk("int status", 0, d);
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200_000;
    error_cnt++;
    results();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_gate();
    t_count();
    t_noack();
    results();
  end
endmodule
